// file: scsl_top.sv
`timescale 1ns/100ps
`default_nettype none

module scsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : scsl_fifo

module scsl_top #(
  parameter int FIFO_DEPTH = scsl_pkg::SCSL_FIFO_DEPTH
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire scsl_pkg::scsl_sfr_req_s sfr_req,
  output var  logic [7:0]              sfr_rdata,
  input  wire logic                    master_enable,
  input  wire logic                    irq_enable,
  output var  logic                    irq,
  input  wire logic                    slave_select_in,
  output var  logic                    slave_select_out,
  output var  logic                    slave_select_oe,
  input  wire logic                    link_clk,
  input  wire logic                    link_data_in,
  output var  logic                    link_data_out
);
  import scsl_pkg::*;

  // ----------------------------------------
  // core side state
  // ----------------------------------------
  logic [3:0]     flags_reg;
  logic [1:0]     mode_reg;
  logic           en_reg;
  logic [7:0]     sfr_rdata_reg;
  logic           irq_reg;
  logic           ss_out_reg;
  logic           ss_oe_reg;
  scsl_tx_state_e tx_st_reg;
  logic [7:0]     tx_hold_reg;
  logic           tx_req_tgl_reg;
  logic [2:0]     sync_meta_reg;
  logic [2:0]     sync_reg;
  logic           done_prev_reg;
  logic [7:0]     ctrl_view;
  logic [7:0]     ctrl_sw;
  logic           ctrl_we;
  logic [3:0]     hw_set;
  logic           data_wr;
  logic           data_rd;
  logic           tx_accept;
  logic           done_evt;
  logic           write_collision_flag_evt;
  logic           mode_fault_flag_evt;
  logic           ovrn_evt;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic [7:0]     fifo_out_data;
  logic           ss_sync;
  logic           ack_sync;
  logic           done_sync;

  // ----------------------------------------
  // link side state
  // ----------------------------------------
  logic           lrst_meta_reg;
  logic           lrst_reg;
  logic           req_meta_reg;
  logic           req_sync_reg;
  logic [7:0]     shift_reg;
  logic [2:0]     bit_cnt_reg;
  logic           ack_tgl_reg;
  logic           done_tgl_reg;
  logic [7:0]     rx_hold_reg;
  logic           link_out_reg;
  logic [7:0]     shift_src;

  assign ss_sync   = sync_reg[2];
  assign ack_sync  = sync_reg[1];
  assign done_sync = sync_reg[0];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign ctrl_view = {flags_reg, mode_reg, (tx_st_reg == SCSL_TX_EMPTY), en_reg};
  assign data_wr   = sfr_req.wr && (sfr_req.addr == SCSL_DATA_ADDR);
  assign data_rd   = sfr_req.rd && (sfr_req.addr == SCSL_DATA_ADDR);

  always_comb begin
    ctrl_sw = ctrl_view;
    ctrl_we = 1'b0;
    if (sfr_req.wr && (sfr_req.addr == SCSL_CTRL_ADDR)) begin
      ctrl_sw = sfr_req.wdata;
      ctrl_we = 1'b1;
    end else if (sfr_req.bit_wr && (sfr_req.bit_addr[7:3] == SCSL_CTRL_ADDR[7:3])) begin
      ctrl_sw[sfr_req.bit_addr[2:0]] = sfr_req.bit_wdata;
      ctrl_we = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_reg <= SCSL_CTRL_RESET[SCSL_MODE_HI:SCSL_MODE_LO];
      en_reg   <= SCSL_CTRL_RESET[SCSL_EN_BIT];
    end else if (ctrl_we) begin
      mode_reg <= ctrl_sw[SCSL_MODE_HI:SCSL_MODE_LO];
      en_reg   <= ctrl_sw[SCSL_EN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata_reg <= 8'h00;
    end else if (sfr_req.rd) begin
      if (sfr_req.addr == SCSL_CTRL_ADDR) begin
        sfr_rdata_reg <= ctrl_view;
      end else if (sfr_req.addr == SCSL_DATA_ADDR) begin
        sfr_rdata_reg <= fifo_out_valid ? fifo_out_data : 8'h00;
      end else begin
        sfr_rdata_reg <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  // transfer done event
  assign done_evt = (done_sync != done_prev_reg);
  assign write_collision_flag_evt = data_wr && (tx_st_reg != SCSL_TX_EMPTY);
  assign mode_fault_flag_evt = en_reg && master_enable && (mode_reg == SCSL_MODE_4W_INPUT) && !ss_sync;
  assign ovrn_evt = done_evt && !master_enable && !fifo_in_ready;
  assign hw_set   = {done_evt, write_collision_flag_evt, mode_fault_flag_evt, ovrn_evt};

  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge core_clk) begin
      if (reset) begin
        flags_reg[i] <= SCSL_CTRL_RESET[SCSL_FLAG_LO + i];
      end else if (hw_set[i]) begin
        flags_reg[i] <= 1'b1;
      end else if (ctrl_we) begin
        flags_reg[i] <= ctrl_sw[SCSL_FLAG_LO + i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_enable && (flags_reg != 4'h0);
    end
  end

  // ----------------------------------------
  // slave select pin
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ss_out_reg <= 1'b1;
      ss_oe_reg  <= 1'b0;
    end else begin
      case (mode_reg)
        SCSL_MODE_DRIVE_LO: begin
          ss_out_reg <= 1'b0;
          ss_oe_reg  <= 1'b1;
        end
        SCSL_MODE_DRIVE_HI: begin
          ss_out_reg <= 1'b1;
          ss_oe_reg  <= 1'b1;
        end
        default: begin
          ss_out_reg <= 1'b1;
          ss_oe_reg  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // crossings into core domain
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_meta_reg <= 3'h4;
      sync_reg      <= 3'h4;
      done_prev_reg <= 1'b0;
    end else begin
      sync_meta_reg <= {slave_select_in, ack_tgl_reg, done_tgl_reg};
      sync_reg      <= sync_meta_reg;
      done_prev_reg <= done_sync;
    end
  end

  // ----------------------------------------
  // transmit buffer handshake
  // ----------------------------------------
  // only accepted writes load
  assign tx_accept = data_wr && (tx_st_reg == SCSL_TX_EMPTY);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_hold_reg    <= 8'h00;
      tx_req_tgl_reg <= 1'b0;
    end else if (tx_accept) begin
      tx_hold_reg    <= sfr_req.wdata;
      tx_req_tgl_reg <= !tx_req_tgl_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_st_reg <= SCSL_TX_EMPTY;
    end else begin
      case (tx_st_reg)
        SCSL_TX_EMPTY: begin
          if (tx_accept) begin
            tx_st_reg <= SCSL_TX_BUSY;
          end
        end
        SCSL_TX_BUSY: begin
          if (ack_sync == tx_req_tgl_reg) begin
            tx_st_reg <= SCSL_TX_EMPTY;
          end
        end
        default: begin
          tx_st_reg <= SCSL_TX_EMPTY;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  scsl_fifo #(
    .WIDTH (SCSL_BYTE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (core_clk),
    .rst       (reset),
    .in_valid  (done_evt),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_hold_reg),
    .out_valid (fifo_out_valid),
    .out_ready (data_rd),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------
  // link domain shifter
  // ----------------------------------------
  assign shift_src = ((bit_cnt_reg == 3'h0) && (req_sync_reg != ack_tgl_reg)) ? tx_hold_reg : shift_reg;

  always_ff @(posedge link_clk) begin
    lrst_meta_reg <= reset;
    lrst_reg      <= lrst_meta_reg;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else begin
      req_meta_reg <= tx_req_tgl_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      ack_tgl_reg  <= 1'b0;
      done_tgl_reg <= 1'b0;
      rx_hold_reg  <= 8'h00;
      link_out_reg <= 1'b0;
    end else begin
      shift_reg    <= {shift_src[6:0], link_data_in};
      link_out_reg <= shift_src[7];
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      if ((bit_cnt_reg == 3'h0) && (req_sync_reg != ack_tgl_reg)) begin
        ack_tgl_reg <= req_sync_reg;
      end
      if (bit_cnt_reg == SCSL_LAST_BIT) begin
        rx_hold_reg  <= {shift_src[6:0], link_data_in};
        done_tgl_reg <= !done_tgl_reg;
      end
    end
  end

  assign sfr_rdata        = sfr_rdata_reg;
  assign irq              = irq_reg;
  assign slave_select_out = ss_out_reg;
  assign slave_select_oe  = ss_oe_reg;
  assign link_data_out    = link_out_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_done_set: assert property (@(posedge core_clk) disable iff (reset)
    done_evt |=> flags_reg[3]) else $error("done flag not set");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (reset)
    (flags_reg != 4'h0) && !ctrl_we |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag cleared without software");
  chk_irq_raise: assert property (@(posedge core_clk) disable iff (reset)
    (hw_set != 4'h0) && irq_enable ##1 irq_enable |=> irq_reg) else $error("no interrupt");
  chk_write_collision_flag_set: assert property (@(posedge core_clk) disable iff (reset)
    data_wr && (tx_st_reg == SCSL_TX_BUSY) |=> flags_reg[2]) else $error("collision missed");
  chk_write_collision_flag_drop: assert property (@(posedge core_clk) disable iff (reset)
    data_wr && (tx_st_reg == SCSL_TX_BUSY) |=> $stable(tx_hold_reg)) else $error("colliding write stored");
  chk_mode_fault_flag_set: assert property (@(posedge core_clk) disable iff (reset)
    en_reg && master_enable && (mode_reg == 2'h1) && !ss_sync |=> flags_reg[1]) else $error("mode fault missed");
  chk_ovrn_slave: assert property (@(posedge core_clk) disable iff (reset)
    done_evt && !fifo_in_ready && !master_enable |=> flags_reg[0]) else $error("overrun missed");
  chk_ovrn_master: assert property (@(posedge core_clk) disable iff (reset)
    master_enable && !flags_reg[0] && !(ctrl_we && ctrl_sw[SCSL_OVRN_BIT]) |=> !flags_reg[0])
    else $error("overrun in master mode");
  chk_ss_float: assert property (@(posedge core_clk) disable iff (reset)
    !mode_reg[1] |=> !ss_oe_reg) else $error("select driven in input mode");
  chk_ss_low: assert property (@(posedge core_clk) disable iff (reset)
    mode_reg == 2'h2 |=> ss_oe_reg && !ss_out_reg) else $error("select not low");
  chk_ss_high: assert property (@(posedge core_clk) disable iff (reset)
    mode_reg == 2'h3 |=> ss_oe_reg && ss_out_reg) else $error("select not high");
  chk_tbe_clear: assert property (@(posedge core_clk) disable iff (reset)
    tx_accept |=> !ctrl_view[SCSL_TBE_BIT] ##1 !ctrl_view[SCSL_TBE_BIT]) else $error("empty not cleared");
  chk_tbe_return: assert property (@(posedge core_clk) disable iff (reset)
    tx_st_reg == SCSL_TX_BUSY && ack_sync == tx_req_tgl_reg |=> ctrl_view[SCSL_TBE_BIT])
    else $error("empty not restored");
  chk_set_wins: assert property (@(posedge core_clk) disable iff (reset)
    hw_set[3] && ctrl_we && !ctrl_sw[SCSL_DONE_BIT] |=> flags_reg[3]) else $error("clear beat set");
  cov_collision: cover property (@(posedge core_clk) disable iff (reset) write_collision_flag_evt);
  cov_overrun: cover property (@(posedge core_clk) disable iff (reset) ovrn_evt);
  cov_tx_cycle: cover property (@(posedge core_clk) disable iff (reset) tx_accept ##[1:200] done_evt);
endmodule : scsl_top
`default_nettype wire

// file: scsl_pkg.sv
`default_nettype none
package scsl_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] SCSL_CTRL_ADDR  = 8'hF8;
  localparam logic [7:0] SCSL_DATA_ADDR  = 8'hA3;
  localparam logic [7:0] SCSL_CTRL_RESET = 8'h06;
  localparam int         SCSL_DONE_BIT   = 7;
  localparam int         SCSL_WRITE_COLLISION_FLAG_BIT   = 6;
  localparam int         SCSL_MODE_FAULT_FLAG_BIT   = 5;
  localparam int         SCSL_OVRN_BIT   = 4;
  localparam int         SCSL_MODE_HI    = 3;
  localparam int         SCSL_MODE_LO    = 2;
  localparam int         SCSL_TBE_BIT    = 1;
  localparam int         SCSL_EN_BIT     = 0;
  localparam int         SCSL_FLAG_LO    = 4;

  // ----------------------------------------
  // select modes and sizes
  // ----------------------------------------
  localparam logic [1:0] SCSL_MODE_3WIRE    = 2'h0;
  localparam logic [1:0] SCSL_MODE_4W_INPUT = 2'h1;
  localparam logic [1:0] SCSL_MODE_DRIVE_LO = 2'h2;
  localparam logic [1:0] SCSL_MODE_DRIVE_HI = 2'h3;
  localparam int         SCSL_BYTE_BITS     = 8;
  localparam int         SCSL_FIFO_DEPTH    = 16;
  localparam logic [2:0] SCSL_LAST_BIT      = 3'h7;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [7:0] bit_addr;
    logic       bit_wdata;
  } scsl_sfr_req_s;

  typedef enum logic [1:0] {
    SCSL_TX_EMPTY = 2'b01,
    SCSL_TX_BUSY  = 2'b10
  } scsl_tx_state_e;
endpackage : scsl_pkg
`default_nettype wire

// file: scsl_fifo_note_unused.sv
`default_nettype none
`default_nettype wire

// file: scsl_link_partner.sv
`timescale 1ns/100ps
`default_nettype none
module scsl_link_partner (
  output var  logic link_clk,
  output var  logic link_data_in,
  input  wire logic link_data_out
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    link_clk     = 1'b0;
    link_data_in = 1'b0;
  end

  // ----------------------------------------
  // one frame, msb first
  // ----------------------------------------
  // clock stands still between frames, data line shows inverse of last bit
  task automatic send_frame(input logic [7:0] tx_byte, output int ones_seen);
    ones_seen = 0;
    for (int i = 7; i >= 0; i--) begin
      link_data_in = tx_byte[i];
      #40;
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
      if (link_data_out === 1'b1) begin
        ones_seen++;
      end
      #40;
    end
    link_data_in = ~tx_byte[0];
  endtask : send_frame

  // ----------------------------------------
  // bare clock pulses, data held
  // ----------------------------------------
  task automatic run_clock(input int n);
    repeat (n) begin
      #40;
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
      #40;
    end
  endtask : run_clock
endmodule : scsl_link_partner
`default_nettype wire

// file: scsl_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module scsl_top_tb_top;
  import scsl_pkg::*;
  logic          core_clk;
  logic          reset;
  scsl_sfr_req_s sfr_req;
  logic [7:0]    sfr_rdata;
  logic          master_enable;
  logic          irq_enable;
  logic          irq;
  logic          ss_ext;
  logic          ss_pin;
  logic          slave_select_out;
  logic          slave_select_oe;
  logic          link_clk;
  logic          link_data_in;
  logic          link_data_out;
  int            err_total;
  int            samples_checked;
  int            ones;
  int            hits;
  logic [7:0]    rd_val;

  // ----------------------------------------
  // pin, design and far side
  // ----------------------------------------
  assign ss_pin = slave_select_oe ? slave_select_out : ss_ext;

  scsl_top #(.FIFO_DEPTH(16)) scsl_top_inst (
    .core_clk         (core_clk),
    .reset            (reset),
    .sfr_req          (sfr_req),
    .sfr_rdata        (sfr_rdata),
    .master_enable    (master_enable),
    .irq_enable       (irq_enable),
    .irq              (irq),
    .slave_select_in  (ss_pin),
    .slave_select_out (slave_select_out),
    .slave_select_oe  (slave_select_oe),
    .link_clk         (link_clk),
    .link_data_in     (link_data_in),
    .link_data_out    (link_data_out)
  );

  scsl_link_partner scsl_link_partner_inst (
    .link_clk      (link_clk),
    .link_data_in  (link_data_in),
    .link_data_out (link_data_out)
  );

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    err_total++;
    $display("BAD at %0t: watchdog expired", $time);
    wrap_up();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    sfr_req.addr  <= addr;
    sfr_req.wdata <= data;
    sfr_req.wr    <= 1'b1;
    @(posedge core_clk);
    sfr_req.wr    <= 1'b0;
  endtask : sfr_wr

  task automatic sfr_bit(input logic [2:0] bit_no, input logic val);
    @(posedge core_clk);
    sfr_req.bit_addr  <= SCSL_CTRL_ADDR | {5'h00, bit_no};
    sfr_req.bit_wdata <= val;
    sfr_req.bit_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_req.bit_wr    <= 1'b0;
  endtask : sfr_bit

  task automatic sfr_rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    sfr_req.addr <= addr;
    sfr_req.rd   <= 1'b1;
    @(posedge core_clk);
    sfr_req.rd   <= 1'b0;
    #1;
    data = sfr_rdata;
  endtask : sfr_rd

  task automatic ctrl_is(input logic [7:0] exp, input string what);
    sfr_rd(SCSL_CTRL_ADDR, rd_val);
    chk8(rd_val, exp, what);
  endtask : ctrl_is

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_total       = 0;
    samples_checked = 0;
    reset           = 1'b1;
    sfr_req         = '0;
    master_enable   = 1'b0;
    irq_enable      = 1'b0;
    ss_ext          = 1'b1;
    // link reset needs link edges while reset is held
    fork
      scsl_link_partner_inst.run_clock(3);
      repeat (6) @(posedge core_clk);
    join
    reset <= 1'b0;
    idle(1);
    chk1(slave_select_oe, 1'b0, "select pin default input");
    chk1(irq, 1'b0, "irq after reset");
    ctrl_is(SCSL_CTRL_RESET, "control reset value");
    sfr_rd(8'h00, rd_val);
    chk8(rd_val, 8'h00, "unmapped read");
    // two edges release the link reset so frames start at bit 0
    scsl_link_partner_inst.run_clock(2);
    idle(10);
    sfr_wr(SCSL_CTRL_ADDR, 8'h05);
    // select modes, tx empty bit ignores writes
    for (int m = 0; m < 4; m++) begin
      sfr_wr(SCSL_CTRL_ADDR, {4'h0, m[1:0], 2'b01});
      idle(3);
      ctrl_is({4'h0, m[1:0], 2'b11}, "mode readback");
      chk1(slave_select_oe, m >= 2, "select pin enable");
      if (m >= 2) begin
        chk1(slave_select_out, m[0], "select pin level");
      end
    end
    // mode fault only in mode 01
    @(posedge core_clk);
    master_enable <= 1'b1;
    irq_enable    <= 1'b1;
    sfr_wr(SCSL_CTRL_ADDR, 8'h09);
    ss_ext <= 1'b0;
    idle(8);
    ctrl_is(8'h0B, "no fault while driving");
    chk1(irq, 1'b0, "irq idle");
    sfr_wr(SCSL_CTRL_ADDR, 8'h05);
    idle(8);
    ctrl_is(8'h27, "mode fault set");
    chk1(irq, 1'b1, "irq on fault");
    ss_ext <= 1'b1;
    idle(8);
    ctrl_is(8'h27, "mode fault held");
    sfr_bit(3'h5, 1'b0);
    idle(3);
    ctrl_is(8'h07, "bit clear of fault");
    chk1(irq, 1'b0, "irq after clear");
    irq_enable <= 1'b0;
    sfr_bit(3'h7, 1'b1);
    idle(3);
    chk1(irq, 1'b0, "irq masked");
    irq_enable <= 1'b1;
    idle(3);
    chk1(irq, 1'b1, "irq unmasked");
    sfr_wr(SCSL_CTRL_ADDR, 8'h05);
    // transmit buffer and collision
    @(posedge core_clk);
    master_enable <= 1'b0;
    sfr_wr(SCSL_DATA_ADDR, 8'h07);
    ctrl_is(8'h05, "tx buffer full");
    sfr_wr(SCSL_DATA_ADDR, 8'hF0);
    ctrl_is(8'h45, "write collision");
    scsl_link_partner_inst.send_frame(8'hFF, ones);
    scsl_link_partner_inst.send_frame(8'hFF, ones);
    chk8(8'(ones), 8'h03, "dropped write kept out");
    idle(10);
    ctrl_is(8'hC7, "done and tx empty");
    scsl_link_partner_inst.send_frame(8'hFF, ones);
    sfr_wr(SCSL_CTRL_ADDR, 8'h05);
    // fill receive fifo, overrun only as slave
    for (int i = 0; i < 16; i++) begin
      sfr_rd(SCSL_DATA_ADDR, rd_val);
    end
    @(posedge core_clk);
    master_enable <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      scsl_link_partner_inst.send_frame(8'hFF, ones);
    end
    idle(10);
    ctrl_is(8'h87, "no overrun as master");
    master_enable <= 1'b0;
    scsl_link_partner_inst.send_frame(8'hFF, ones);
    idle(10);
    ctrl_is(8'h97, "overrun as slave");
    for (int i = 0; i < 16; i++) begin
      sfr_rd(SCSL_DATA_ADDR, rd_val);
      chk8(rd_val, 8'hFF, "received byte");
    end
    sfr_rd(SCSL_DATA_ADDR, rd_val);
    chk8(rd_val, 8'h00, "empty fifo read");
    ctrl_is(8'h97, "flags kept after drain");
    // clear strobe held across a frame end
    sfr_wr(SCSL_CTRL_ADDR, 8'h05);
    idle(3);
    hits = 0;
    fork
      scsl_link_partner_inst.send_frame(8'hFF, ones);
      begin
        @(posedge core_clk);
        sfr_req.addr  <= SCSL_CTRL_ADDR;
        sfr_req.wdata <= 8'h05;
        sfr_req.wr    <= 1'b1;
        repeat (44) begin
          @(negedge core_clk);
          if (irq === 1'b1) begin
            hits++;
          end
        end
        @(posedge core_clk);
        sfr_req.wr <= 1'b0;
      end
    join
    chk8(8'(hits), 8'h01, "done set beats held clear");
    ctrl_is(8'h07, "held clear wins afterwards");
    wrap_up();
  end
endmodule : scsl_top_tb_top
`default_nettype wire
